// [core/clfmr_refgen.sv]
// reference generator: divide-by-four on both clocks, shared long divider
// assumes clock inputs arrive as one-cycle ticks synchronous to clock
`timescale 1ns/1ps
`include "clfmr_defs.svh"
module clfmr_refgen
    import clfmr_pkg::*;
(
    // system
    input  wire logic clock,
    input  wire logic rst,
    // link to top
    clfmr_ref_if.gen  rif
);
    logic [`CLFMR_QUAD_BITS-1:0] quad_base_r;
    logic [`CLFMR_QUAD_BITS-1:0] quad_ext_r;
    logic [`CLFMR_LONG_BITS-1:0] long_r;
    logic                        stab_prev_r;
    logic                        long_tick;
    logic                        base_q_tick;
    logic                        ext_q_tick;
    logic                        stab_clk;
    logic                        long_msb;

    // ----------------------------------------------------------------
    // divide-by-four stages
    // ----------------------------------------------------------------
    // fixed quarter stage
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            quad_base_r <= '0;
            quad_ext_r  <= '0;
        end else begin
            quad_base_r <= quad_base_r + {1'b0, rif.base_tick};
            quad_ext_r  <= quad_ext_r + {1'b0, rif.ext_tick};
        end
    end
    assign base_q_tick = rif.base_tick && (quad_base_r == 2'h3);
    assign ext_q_tick  = rif.ext_tick && (quad_ext_r == 2'h3);

    // ----------------------------------------------------------------
    // long divider
    // ----------------------------------------------------------------
    // stabilize runs on ext clock
    assign long_tick = rif.stab_mode ? rif.ext_tick
                     : (rif.long_on_base ? base_q_tick : ext_q_tick);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            long_r      <= '0;
            stab_prev_r <= 1'b0;
        end else if (rif.long_rst) begin
            long_r      <= '0;
            stab_prev_r <= 1'b0;
        end else begin
            long_r      <= long_r + {{(`CLFMR_LONG_BITS-1){1'b0}}, long_tick};
            stab_prev_r <= stab_clk;
        end
    end

    assign stab_clk = rif.crystal_enable ? long_r[`CLFMR_LONG_BITS-1] : long_r[3];
    // falling edge marks the end of stabilizing
    assign rif.stab_fall = stab_prev_r && !stab_clk;
    assign long_msb      = long_r[`CLFMR_LONG_BITS-1];

    // long divide ratio on one path, keeps refs at most half
    assign rif.ext_ref_clk = rif.long_on_base ? quad_ext_r[1] : long_msb;
    assign rif.int_ref_clk = rif.long_on_base ? long_msb : quad_base_r[1];

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    long_hold_a: assert property (@(posedge clock) disable iff (rst)
        rif.long_rst |=> long_r == '0)
        else $error("long divider not held");
    stab_count_a: assert property (@(posedge clock) disable iff (rst)
        rif.stab_mode && !rif.long_rst && rif.ext_tick |=> long_r == $past(long_r) + 12'h001)
        else $error("stabilize count missed a tick");
endmodule

// [core/clfmr_top.sv]
// loop filter, oscillator pin enables and clock monitor reference generator
// assumes base and external clocks arrive as ticks synchronous to clock; all
// configuration bits are plain synchronous inputs
`timescale 1ns/1ps
`include "clfmr_defs.svh"
// Contract
// - divider and stage fields form one twelve bit word, signed correction.
// - slow clock subtracts 32, 8 or 1 by error band.
// - fast clock adds 1, 8 or 32 by error band.
// - correction hits stage field; divider takes carry or borrow.
// - out of range divider A to F acts as slowest setting 9.
// - recovery uses normal subtraction; settling at A to F allowed.
// - filter stable asserted when error within five percent.
// - crystal amplifier on only with generator enable and crystal enable.
// - external input path on whenever generator enable is set.
// - with monitor enabled both clocks checked continuously.
// - references derive from external clock and base clock.
// - each reference at most half the other clock.
// - both clocks divided by four; long divider on one.
// - long divider divides by 4096, doubles as stabilization timer.
// - long divider held in reset while generator enable clear.
// - unstable: long divider on ext clock, tap 16 or 4096.
// - falling stabilize edge sets stable flag; divider returns to reference.
// - later stabilize edges never clear the stable flag.
// - inactivity clear returns long divider to stabilizing.
// - generator enable equals on bit and not stop.
// - stable flag clears on enable low or external inactivity.
module clfmr_top
    import clfmr_pkg::*;
(
    // system
    input  wire logic        clock,
    input  wire logic        rst,
    // clocks as ticks
    input  wire logic        base_clk,
    input  wire logic        ext_clk,
    // frequency comparator
    input  wire logic        err_valid,
    input  wire clfmr_err_t  err_band,
    input  wire logic        err_within5,
    // configuration
    input  wire logic        ext_gen_on,
    input  wire logic        clkgen_stop,
    input  wire logic        crystal_enable,
    input  wire logic        slow_crystal_sel,
    input  wire logic        monitor_enable,
    // activity detector
    input  wire logic        ext_inactive,
    // oscillator control
    output logic [3:0]       osc_divider_ctrl,
    output logic [7:0]       osc_stage_ctrl,
    output logic [3:0]       digital_osc_div,
    output logic             filter_stable,
    // pin and path enables
    output logic             ext_gen_enable,
    output logic             amp_enable,
    output logic             osc_out_pin_port,
    output logic             ext_path_enable,
    output logic             osc_in_pin_port,
    // monitor
    output logic             monitor_active,
    output logic             ext_stable_flag,
    output logic             ext_ref_clk,
    output logic             int_ref_clk,
    output logic             stabilize_done
);
    logic [11:0]    word_r;
    logic [11:0]    word_nxt;
    logic           fstab_r;
    logic           gen_en_r;
    logic           amp_r;
    logic           path_r;
    logic           mon_r;
    logic           stable_r;
    logic           stable_nxt;
    logic           ext_ref_clk_r;
    logic           int_ref_clk_r;
    logic           done_r;
    logic           port_out_r;
    logic           port_in_r;
    logic [3:0]     odiv_r;
    logic [7:0]     step;
    logic           step_up;
    logic           gen_en_nxt;
    clfmr_ld_mode_t ld_mode;

    clfmr_ref_if rif();

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    function automatic logic [7:0] band_step(input clfmr_err_t b);
        case (b)
            CLFMR_ERR_LO_BIG, CLFMR_ERR_HI_BIG:   band_step = `CLFMR_STEP_BIG;
            CLFMR_ERR_LO_MID, CLFMR_ERR_HI_MID:   band_step = `CLFMR_STEP_MID;
            default:                              band_step = `CLFMR_STEP_ONE;
        endcase
    endfunction

    // A to F come from the unclamped word running past 9FF or wrapping below zero; the oscillator has nothing slower than 9
    function automatic logic [3:0] eff_div(input logic [3:0] d);
        eff_div = (d > `CLFMR_DIV_SLOW) ? `CLFMR_DIV_SLOW : d;
    endfunction

    assign step    = band_step(err_band);
    assign step_up = (err_band == CLFMR_ERR_HI_SMALL) || (err_band == CLFMR_ERR_HI_MID)
                  || (err_band == CLFMR_ERR_HI_BIG);
    // twelve bit add carries into divider field; no clamping
    assign word_nxt = !err_valid ? word_r
                    : (step_up ? word_r + {4'h0, step} : word_r - {4'h0, step});

    assign gen_en_nxt = ext_gen_on && !clkgen_stop;

    // clear wins only for loss of enable or inactivity; set otherwise sticks
    assign stable_nxt = (!gen_en_r || ext_inactive) ? 1'b0 : (stable_r || rif.stab_fall);
    // unstable flag puts divider in stabilizing role
    assign ld_mode = stable_r ? CLFMR_LD_REF : CLFMR_LD_STAB;

    // base clock stands for the fast internal clock
    assign rif.base_tick      = base_clk;
    assign rif.ext_tick       = ext_clk;
    assign rif.long_rst       = !gen_en_r;
    // slow crystal moves long divider to base path
    assign rif.long_on_base   = slow_crystal_sel;
    // stabilizing counts raw ext ticks, skipping the quarter stage, so 16 means 16
    assign rif.stab_mode      = (ld_mode == CLFMR_LD_STAB);
    assign rif.crystal_enable = crystal_enable;

    clfmr_refgen u_refgen (
        .clock (clock),
        .rst   (rst),
        .rif   (rif)
    );

    // ----------------------------------------------------------------
    // loop filter
    // ----------------------------------------------------------------
    // one measurement moves the word once; between measurements it holds
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            word_r  <= `CLFMR_WORD_RST;
            fstab_r <= 1'b0;
            odiv_r  <= `CLFMR_DIV_SLOW;
        end else begin
            word_r  <= word_nxt;
            fstab_r <= err_valid ? err_within5 : fstab_r;
            // divider above 9 acts as 9
            odiv_r  <= eff_div(word_nxt[11:8]);
        end
    end

    // ----------------------------------------------------------------
    // enables and monitor
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            gen_en_r <= 1'b0;
            amp_r    <= 1'b0;
            path_r   <= 1'b0;
            mon_r    <= 1'b0;
            stable_r <= 1'b0;
            ext_ref_clk_r   <= 1'b0;
            int_ref_clk_r   <= 1'b0;
            done_r   <= 1'b0;
            port_out_r <= 1'b1;
            port_in_r  <= 1'b1;
        end else begin
            gen_en_r <= gen_en_nxt;
            amp_r    <= gen_en_nxt && crystal_enable;
            path_r   <= gen_en_nxt;
            // monitor checks both clocks while enabled
            mon_r    <= monitor_enable;
            stable_r <= stable_nxt;
            // references held apart from their clocks
            ext_ref_clk_r   <= rif.ext_ref_clk;
            int_ref_clk_r   <= rif.int_ref_clk;
            done_r   <= rif.stab_fall;
            // pins go back to port use whenever their oscillator role is off
            port_out_r <= !(gen_en_nxt && crystal_enable);
            port_in_r  <= !gen_en_nxt;
        end
    end

    assign osc_divider_ctrl = word_r[11:8];
    assign osc_stage_ctrl   = word_r[7:0];
    assign digital_osc_div  = odiv_r;
    assign filter_stable    = fstab_r;
    assign ext_gen_enable   = gen_en_r;
    assign amp_enable       = amp_r;
    assign osc_out_pin_port = port_out_r;
    assign ext_path_enable  = path_r;
    assign osc_in_pin_port  = port_in_r;
    assign monitor_active   = mon_r;
    assign ext_stable_flag  = stable_r;
    assign ext_ref_clk      = ext_ref_clk_r;
    assign int_ref_clk      = int_ref_clk_r;
    assign stabilize_done   = done_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence big_low_s;
        err_valid && err_band == CLFMR_ERR_LO_BIG;
    endsequence
    sequence mid_low_s;
        err_valid && err_band == CLFMR_ERR_LO_MID;
    endsequence
    sequence small_low_s;
        err_valid && err_band == CLFMR_ERR_LO_SMALL;
    endsequence
    sequence small_high_s;
        err_valid && err_band == CLFMR_ERR_HI_SMALL;
    endsequence
    sequence big_high_s;
        err_valid && err_band == CLFMR_ERR_HI_BIG;
    endsequence

    word_step_big_a: assert property (@(posedge clock) disable iff (rst)
        big_low_s |=> word_r == $past(word_r) - 12'h020)
        else $error("big low step wrong");
    word_step_up_a: assert property (@(posedge clock) disable iff (rst)
        err_valid && err_band == CLFMR_ERR_HI_MID |=> word_r == $past(word_r) + 12'h008)
        else $error("mid high step wrong");
    word_hold_a: assert property (@(posedge clock) disable iff (rst)
        !err_valid |=> $stable(word_r))
        else $error("word moved without measurement");
    // one check per band, so a swapped step size shows up
    word_step_mid_a: assert property (@(posedge clock) disable iff (rst)
        mid_low_s |=> word_r == $past(word_r) - 12'h008)
        else $error("mid low step wrong");
    word_step_one_a: assert property (@(posedge clock) disable iff (rst)
        small_low_s |=> word_r == $past(word_r) - 12'h001)
        else $error("small low step wrong");
    word_up_one_a: assert property (@(posedge clock) disable iff (rst)
        small_high_s |=> word_r == $past(word_r) + 12'h001)
        else $error("small high step wrong");
    word_up_big_a: assert property (@(posedge clock) disable iff (rst)
        big_high_s |=> word_r == $past(word_r) + 12'h020)
        else $error("big high step wrong");
    div_follow_a: assert property (@(posedge clock) disable iff (rst)
        err_valid |=> osc_divider_ctrl > 4'h9 || digital_osc_div == osc_divider_ctrl)
        else $error("divider not passed through");
    fstab_hold_a: assert property (@(posedge clock) disable iff (rst)
        !err_valid |=> $stable(filter_stable))
        else $error("filter stable moved without measurement");
    div_slow_a: assert property (@(posedge clock) disable iff (rst)
        word_r[11:8] > 4'h9 |-> digital_osc_div == 4'h9)
        else $error("divider not treated as slowest");
    fstab_follow_a: assert property (@(posedge clock) disable iff (rst)
        err_valid |=> filter_stable == $past(err_within5))
        else $error("filter stable wrong");
    amp_gate_a: assert property (@(posedge clock) disable iff (rst)
        ##1 amp_enable == ($past(ext_gen_on) && !$past(clkgen_stop) && $past(crystal_enable)))
        else $error("amplifier gating wrong");
    path_gate_a: assert property (@(posedge clock) disable iff (rst)
        ##1 ext_path_enable == ($past(ext_gen_on) && !$past(clkgen_stop))
            && ext_path_enable != osc_in_pin_port && ext_path_enable == ext_gen_enable)
        else $error("input path gating wrong");
    stable_clear_a: assert property (@(posedge clock) disable iff (rst)
        ext_inactive |=> !ext_stable_flag)
        else $error("stable flag not cleared");
    stable_set_a: assert property (@(posedge clock) disable iff (rst)
        rif.stab_fall && gen_en_r && !ext_inactive |=> ext_stable_flag)
        else $error("stable flag not set");
    stable_keep_a: assert property (@(posedge clock) disable iff (rst)
        ext_stable_flag && gen_en_r && !ext_inactive |=> ext_stable_flag)
        else $error("stable flag dropped");

    // ----------------------------------------------------------------
    // pin and flag checks
    // ----------------------------------------------------------------
    // pins are held against the raw inputs, not the enable flop, so a shared fault shows
    // the flag may only rise on a stabilize fall; without one a clear flag stays clear
    gen_enable_a: assert property (@(posedge clock) disable iff (rst)
        ##1 ext_gen_enable == ($past(ext_gen_on) && !$past(clkgen_stop)))
        else $error("generator enable wrong");
    port_out_a: assert property (@(posedge clock) disable iff (rst)
        ##1 osc_out_pin_port == !($past(ext_gen_on) && !$past(clkgen_stop) && $past(crystal_enable)))
        else $error("second pin port use wrong");
    port_in_a: assert property (@(posedge clock) disable iff (rst)
        ##1 osc_in_pin_port == !($past(ext_gen_on) && !$past(clkgen_stop)))
        else $error("first pin port use wrong");
    monitor_follow_a: assert property (@(posedge clock) disable iff (rst)
        ##1 monitor_active == $past(monitor_enable))
        else $error("monitor enable not followed");
    stable_off_a: assert property (@(posedge clock) disable iff (rst)
        !gen_en_r |=> !ext_stable_flag)
        else $error("stable flag kept while generator off");
    stable_only_a: assert property (@(posedge clock) disable iff (rst)
        !ext_stable_flag && !rif.stab_fall |=> !ext_stable_flag)
        else $error("stable flag set without stabilize edge");
    done_pulse_a: assert property (@(posedge clock) disable iff (rst)
        rif.stab_fall |=> stabilize_done)
        else $error("stabilize done missing");
endmodule

// [pkg/clfmr_defs.svh]
// constants for the clock loop filter, enable logic and monitor reference generator
// assumes inclusion by bare name from the design files
`ifndef CLFMR_DEFS_SVH
`define CLFMR_DEFS_SVH

// ----------------------------------------------------------------
// loop filter word
// ----------------------------------------------------------------
`define CLFMR_WORD_RST    12'h800
`define CLFMR_WORD_MAX    12'h9FF
`define CLFMR_DIV_SLOW    4'h9
`define CLFMR_STEP_BIG    8'h20
`define CLFMR_STEP_MID    8'h08
`define CLFMR_STEP_ONE    8'h01

// ----------------------------------------------------------------
// reference dividers
// ----------------------------------------------------------------
`define CLFMR_QUAD_BITS   2
`define CLFMR_LONG_BITS   12
`define CLFMR_STAB_SHORT  16
`define CLFMR_STAB_LONG   4096

`endif

// [pkg/clfmr_pkg.sv]
// types shared by the clock loop filter block
// assumes nothing of its surroundings
package clfmr_pkg;
    // measured frequency error band of the base clock
    typedef enum logic [2:0] {
        CLFMR_ERR_LO_BIG,
        CLFMR_ERR_LO_MID,
        CLFMR_ERR_LO_SMALL,
        CLFMR_ERR_HI_SMALL,
        CLFMR_ERR_HI_MID,
        CLFMR_ERR_HI_BIG
    } clfmr_err_t;

    // role of the long divider
    typedef enum logic {
        CLFMR_LD_STAB,
        CLFMR_LD_REF
    } clfmr_ld_mode_t;
endpackage

// [pkg/clfmr_ref_if.sv]
// signals between the top and the reference divider module
// assumes a single clock domain
`timescale 1ns/1ps
interface clfmr_ref_if;
    logic base_tick;
    logic ext_tick;
    logic long_rst;
    logic long_on_base;
    logic stab_mode;
    logic crystal_enable;
    logic stab_fall;
    logic ext_ref_clk;
    logic int_ref_clk;

    modport top (
        output base_tick, ext_tick, long_rst, long_on_base, stab_mode, crystal_enable,
        input  stab_fall, ext_ref_clk, int_ref_clk
    );
    modport gen (
        input  base_tick, ext_tick, long_rst, long_on_base, stab_mode, crystal_enable,
        output stab_fall, ext_ref_clk, int_ref_clk
    );
endinterface

// [verif/tb_clock_loop_filter_monitor_ref.sv]
// self-checking bench for the loop filter, pin enables and monitor reference block
// assumes the package, interface and design files are compiled before it
`timescale 1ns/1ps
module tb_clock_loop_filter_monitor_ref
    import clfmr_pkg::*;
;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    typedef struct packed {
        clfmr_err_t  band;
        logic        w5;
        logic [11:0] word;
    } clfmr_row_t;

    logic        clock = 0, rst = 1, base_clk = 0, ext_clk = 0;
    logic        err_valid = 0, err_within5 = 0, ext_inactive = 0;
    clfmr_err_t  err_band = CLFMR_ERR_LO_BIG;
    logic        ext_gen_on = 0, clkgen_stop = 0, crystal_enable = 0;
    logic        slow_crystal_sel = 0, monitor_enable = 0;
    logic [3:0]  osc_divider_ctrl, digital_osc_div;
    logic [7:0]  osc_stage_ctrl;
    logic        filter_stable, ext_gen_enable, amp_enable, osc_out_pin_port;
    logic        ext_path_enable, osc_in_pin_port, monitor_active, ext_stable_flag;
    logic        ext_ref_clk, int_ref_clk, stabilize_done;
    int          n_errors = 0, samples_checked = 0, itgl, etgl, ndone;
    logic        iq, eq, tclr = 1;
    clfmr_row_t  rows [6];
    wire  [11:0] word = {osc_divider_ctrl, osc_stage_ctrl};

    always #2.5 clock = ~clock;

    clfmr_top u_dut (.clock, .rst, .base_clk, .ext_clk, .err_valid, .err_band, .err_within5,
        .ext_gen_on, .clkgen_stop, .crystal_enable, .slow_crystal_sel, .monitor_enable,
        .ext_inactive, .osc_divider_ctrl, .osc_stage_ctrl, .digital_osc_div, .filter_stable,
        .ext_gen_enable, .amp_enable, .osc_out_pin_port, .ext_path_enable, .osc_in_pin_port,
        .monitor_active, .ext_stable_flag, .ext_ref_clk, .int_ref_clk, .stabilize_done);

    // reference edges and completion pulses are counted, not sampled, so phase is moot
    always @(posedge clock) begin
        iq <= int_ref_clk;
        eq <= ext_ref_clk;
        if (tclr) begin
            itgl  <= 0;
            etgl  <= 0;
            ndone <= 0;
        end else begin
            if (int_ref_clk !== iq) itgl <= itgl + 1;
            if (ext_ref_clk !== eq) etgl <= etgl + 1;
            if (stabilize_done === 1'b1) ndone <= ndone + 1;
        end
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task check(input string what, input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task wrap_up;
        if (n_errors == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // sampling one ns after the edge lets that edge's updates land first
    task cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task filt(input clfmr_err_t band, input logic w5);
        @(posedge clock);
        err_valid   <= 1;
        err_band    <= band;
        err_within5 <= w5;
        @(posedge clock);
        err_valid   <= 0;
        cyc(2);
    endtask

    task ticks(input int n, input logic b, input logic e);
        repeat (n) begin
            @(posedge clock);
            base_clk <= b;
            ext_clk  <= e;
            @(posedge clock);
            base_clk <= 0;
            ext_clk  <= 0;
        end
        cyc(4);
    endtask

    task cfg(input logic on, stop, xtal, slow, mon, inact);
        @(posedge clock);
        ext_gen_on       <= on;
        clkgen_stop      <= stop;
        crystal_enable   <= xtal;
        slow_crystal_sel <= slow;
        monitor_enable   <= mon;
        ext_inactive     <= inact;
        cyc(4);
    endtask

    task refs(input logic slow, input logic [1:0] exp);
        cfg(1, 0, 0, slow, 1, 0);
        tclr = 0;
        ticks(64, 1, 1);
        check("int_ref", (itgl >= 31 && itgl <= 33) ? 1 : (itgl <= 1) ? 0 : 2, exp[1]);
        check("ext_ref", (etgl >= 31 && etgl <= 33) ? 1 : (etgl <= 1) ? 0 : 2, exp[0]);
        check("stable_kept", ext_stable_flag, 1);
        tclr = 1;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic g;
        rows = '{'{CLFMR_ERR_LO_BIG, 1'b0, 12'h7E0}, '{CLFMR_ERR_LO_MID, 1'b0, 12'h7D8},
                 '{CLFMR_ERR_LO_SMALL, 1'b1, 12'h7D7}, '{CLFMR_ERR_HI_SMALL, 1'b1, 12'h7D8},
                 '{CLFMR_ERR_HI_MID, 1'b0, 12'h7E0}, '{CLFMR_ERR_HI_BIG, 1'b0, 12'h800}};
        repeat (5) @(posedge clock);
        rst <= 0;
        cyc(1);
        foreach (rows[i]) begin
            filt(rows[i].band, rows[i].w5);
            check("word", word, rows[i].word);
            check("filter_stable", filter_stable, rows[i].w5);
        end
        for (int i = 0; i < 16; i++) begin
            cfg(i[0], i[1], i[2], 0, i[3], 0);
            g = i[0] & !i[1];
            check("enables", {ext_gen_enable, amp_enable, osc_out_pin_port, ext_path_enable,
                  osc_in_pin_port, monitor_active},
                  {g, g & i[2], !(g & i[2]), g, !g, i[3]});
        end
        // past the top of the range the divider field must read as the slowest setting
        repeat (16) filt(CLFMR_ERR_HI_BIG, 0);
        check("word_over", word, 12'hA00);
        check("div_over", digital_osc_div, 4'h9);
        filt(CLFMR_ERR_LO_SMALL, 0);
        check("word_back", word, 12'h9FF);
        repeat (80) filt(CLFMR_ERR_LO_BIG, 0);
        check("word_under", word, 12'hFFF);
        check("div_under", digital_osc_div, 4'h9);
        filt(CLFMR_ERR_HI_SMALL, 1);
        check("div_wrap", {digital_osc_div, word}, 16'h0000);
        // short stabilization count, then both reference arrangements
        cfg(1, 0, 0, 0, 0, 0);
        tclr = 0;
        ticks(15, 0, 1);
        check("stable_early", ext_stable_flag, 0);
        ticks(1, 0, 1);
        check("stable_set", ext_stable_flag, 1);
        check("done_pulses", ndone, 1);
        tclr = 1;
        refs(0, 2'b10);
        refs(1, 2'b01);
        cfg(1, 0, 0, 1, 0, 1);
        check("stable_inactive", ext_stable_flag, 0);
        cfg(1, 0, 0, 1, 0, 0);
        check("stable_stays_clear", ext_stable_flag, 0);
        // slow crystal keeps the reference path off ext, so only a stabilize role sets again
        ticks(16, 0, 1);
        check("stable_again", ext_stable_flag, 1);
        // crystal timeout: off first so the long divider restarts from zero
        cfg(0, 0, 1, 0, 0, 0);
        cfg(1, 0, 1, 0, 0, 0);
        ticks(4095, 0, 1);
        check("xtal_early", ext_stable_flag, 0);
        ticks(1, 0, 1);
        check("xtal_set", ext_stable_flag, 1);
        cfg(1, 1, 1, 0, 0, 0);
        check("stop_clears", {ext_gen_enable, ext_stable_flag}, 0);
        // second reset in mid-run, checked while it is still applied
        filt(CLFMR_ERR_LO_BIG, 1);
        cfg(1, 0, 1, 0, 1, 0);
        @(posedge clock);
        rst <= 1;
        cyc(2);
        check("rst_word", word, 12'h800);
        check("rst_div", digital_osc_div, 4'h9);
        check("rst_ports", {osc_out_pin_port, osc_in_pin_port}, 2'b11);
        check("rst_flags", {filter_stable, ext_gen_enable, amp_enable, ext_path_enable,
              monitor_active, ext_stable_flag, ext_ref_clk, int_ref_clk, stabilize_done}, 0);
        // quiet inputs before release so the first edge after it is a plain one
        cfg(0, 0, 0, 0, 0, 0);
        @(posedge clock);
        rst <= 0;
        filt(CLFMR_ERR_LO_BIG, 0);
        check("rst_first", {digital_osc_div, word}, 16'h77E0);
        wrap_up;
    end

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    // the run needs about 10000 cycles; six times that means a hang
    initial begin
        repeat (60000) @(posedge clock);
        n_errors++;
        wrap_up;
    end
endmodule
